// file: inc/tsr_pkg.sv
// Package of constants and carrier types for the temperature sensor register bank.
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_UPPER_THRESHOLD  = 8'h02;
  localparam logic [7:0] OFS_LOWER_THRESHOLD  = 8'h03;
  localparam logic [7:0] OFS_NVM_UNLOCK       = 8'h04;
  localparam logic [7:0] OFS_SCRATCH_ONE      = 8'h05;
  localparam logic [7:0] OFS_SCRATCH_TWO      = 8'h06;
  localparam logic [7:0] OFS_CAL_OFFSET       = 8'h07;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         NVM_WRITE_UNLOCK_BIT = 15;
  localparam int         NVM_BUSY_BIT         = 14;
  localparam logic [15:0] RST_UPPER_THRESHOLD = 16'h6000;
  localparam logic [15:0] RST_LOWER_THRESHOLD = 16'h8000;
  localparam logic [15:0] RST_SCRATCH_ONE     = 16'h1234;
  localparam logic [15:0] RST_SCRATCH_TWO     = 16'h0000;
  localparam logic [15:0] RST_CAL_OFFSET      = 16'h0000;
  localparam logic [15:0] RST_NVM_UNLOCK      = 16'h0000;
  localparam logic [15:0] TEMP_MAX_CODE       = 16'h7fff;
  localparam logic [15:0] TEMP_MIN_CODE       = 16'h8000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int NVM_PROG_TIME_US = 7000;
  localparam int NVM_PROG_CYCLES  = (NVM_PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int NVM_LOAD_CYCLES  = 4;

  // ----------------------------------------------------------------
  // Stored-copy word count, indices and types
  // ----------------------------------------------------------------
  localparam int NVM_WORDS = 5;
  localparam logic [2:0] NVM_IDX_UPPER   = 3'h0;
  localparam logic [2:0] NVM_IDX_LOWER   = 3'h1;
  localparam logic [2:0] NVM_IDX_SCR_ONE = 3'h2;
  localparam logic [2:0] NVM_IDX_SCR_TWO = 3'h3;
  localparam logic [2:0] NVM_IDX_CAL     = 3'h4;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tsr_req_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_PROG = 3'b100
  } tsr_state_t;

endpackage

// file: rtl/tsr_regs.sv
// Threshold, scratch, unlock and calibration-offset register bank with non-volatile backing.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Summary of operation
// - The upper alert threshold is a 16-bit two's complement read/write register.
// - After reset or general call the upper threshold reloads from its stored copy, 6000h.
// - The lower alert threshold is a 16-bit two's complement read/write register.
// - After reset the lower threshold reloads from its stored copy, 8000h.
// - With unlock clear, writes touch only the logic registers, not the stored copy.
// - With unlock set, each write to a programmable register while not busy also programs its copy.
// - Bit 14 of the unlock register is a read-only busy flag mirroring the config busy flag.
// - Busy is high during programming or the power-up, reset or general-call reload and low when ready.
// - Scratch words at 05h and 06h are stored-copy backed with the same write behaviour.
// - The stored scratch copies start with a per-unit identifier the host may overwrite.
// - The calibration offset at 07h is added to the linearized result before storage.
// - An out-of-range sum saturates to the maximum or minimum code.
// - The offset uses the result format and resets to 0000h.
// ------------------------------------------------------------------
module tsr_regs
  import tsr_pkg::*;
#(
  parameter int          PROG_CYCLES = NVM_PROG_CYCLES,
  parameter logic [15:0] UNIT_ID_ONE = RST_SCRATCH_ONE,  // Arbitrary value, per-unit identifier.
  parameter logic [15:0] UNIT_ID_TWO = RST_SCRATCH_TWO
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        gcall_reset_i,
  input  wire tsr_req_t    req_i,
  output logic      [15:0] rdata_o,
  output logic             rvalid_o,
  output logic             nvm_busy_o,
  input  wire logic        lin_valid_i,
  input  wire logic [15:0] lin_temp_i,
  output logic      [15:0] temp_result_o,
  output logic             temp_valid_o,
  output logic      [15:0] upper_threshold_o,
  output logic      [15:0] lower_threshold_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PROG_CYCLES < 1)
  begin : g_bad_prog
    $error("PROG_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Saturating add of the calibration offset
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15])
      sat_add = s[16] ? TEMP_MIN_CODE : TEMP_MAX_CODE;
    else
      sat_add = s[15:0];
  endfunction

  function automatic logic [2:0] nvm_index(input logic [7:0] addr);
    if (addr == OFS_UPPER_THRESHOLD)
      nvm_index = NVM_IDX_UPPER;
    else if (addr == OFS_LOWER_THRESHOLD)
      nvm_index = NVM_IDX_LOWER;
    else if (addr == OFS_SCRATCH_ONE)
      nvm_index = NVM_IDX_SCR_ONE;
    else if (addr == OFS_SCRATCH_TWO)
      nvm_index = NVM_IDX_SCR_TWO;
    else
      nvm_index = NVM_IDX_CAL;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The stored copies survive srst_i; only programming changes them.
  logic [15:0] nvm_mem [NVM_WORDS];
  // Starts low at power-up so that the factory contents are written at the first edge;
  // otherwise the stored copies would stay unknown forever.
  logic        nvm_init_r = 1'b0;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] scr_one_r;
  logic [15:0] scr_two_r;
  logic [15:0] cal_r;
  logic        unlock_r;
  tsr_state_t  state_r;
  logic [31:0] cnt_r;
  logic [2:0]  load_idx_r;
  logic        reload;
  logic        is_prog_addr;
  logic        wr_ok;

  assign reload       = srst_i | gcall_reset_i;
  assign is_prog_addr = (req_i.addr >= OFS_UPPER_THRESHOLD) && (req_i.addr <= OFS_CAL_OFFSET)
                        && (req_i.addr != OFS_NVM_UNLOCK);
  assign wr_ok        = req_i.wr && is_prog_addr;

  // ----------------------------------------------------------------
  // Non-volatile copy
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!nvm_init_r)
    begin
      nvm_mem[NVM_IDX_UPPER]   <= RST_UPPER_THRESHOLD;
      nvm_mem[NVM_IDX_LOWER]   <= RST_LOWER_THRESHOLD;
      nvm_mem[NVM_IDX_SCR_ONE] <= UNIT_ID_ONE;
      nvm_mem[NVM_IDX_SCR_TWO] <= UNIT_ID_TWO;
      nvm_mem[NVM_IDX_CAL]     <= RST_CAL_OFFSET;
    end
    else if (!reload && state_r == ST_IDLE && wr_ok && unlock_r)
    begin
      nvm_mem[nvm_index(req_i.addr)] <= req_i.wdata;
    end
  end

  // Factory programming happens once, at the first clock edge of life.
  always_ff @(posedge ref_clk_i)
  begin
    nvm_init_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Busy sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (reload || !nvm_init_r)
    begin
      state_r <= ST_LOAD;
      cnt_r   <= 32'h0000_0000;
    end
    else
    begin
      case (state_r)
        ST_LOAD:
        begin
          if (cnt_r == 32'(NVM_LOAD_CYCLES - 1))
            state_r <= ST_IDLE;
          cnt_r <= cnt_r + 32'h0000_0001;
        end
        ST_IDLE:
        begin
          cnt_r <= 32'h0000_0000;
          if (wr_ok && unlock_r)
            state_r <= ST_PROG;
        end
        ST_PROG:
        begin
          if (cnt_r == 32'(PROG_CYCLES - 1))
            state_r <= ST_IDLE;
          cnt_r <= cnt_r + 32'h0000_0001;
        end
        default:
        begin
          state_r <= ST_LOAD;
        end
      endcase
    end
  end

  assign nvm_busy_o = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Logic registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    load_idx_r <= 3'h0;
    if (reload || !nvm_init_r)
    begin
      upper_r  <= RST_UPPER_THRESHOLD;
      lower_r  <= RST_LOWER_THRESHOLD;
      scr_one_r <= 16'h0000;
      scr_two_r <= 16'h0000;
      cal_r    <= RST_CAL_OFFSET;
    end
    else if (state_r == ST_LOAD)
    begin
      upper_r   <= nvm_mem[NVM_IDX_UPPER];
      lower_r   <= nvm_mem[NVM_IDX_LOWER];
      scr_one_r <= nvm_mem[NVM_IDX_SCR_ONE];
      scr_two_r <= nvm_mem[NVM_IDX_SCR_TWO];
      cal_r     <= nvm_mem[NVM_IDX_CAL];
    end
    else if (req_i.wr && state_r == ST_IDLE)
    begin
      // Writes while busy are dropped, so the logic copy never drifts from a pending program.
      if (req_i.addr == OFS_UPPER_THRESHOLD)
        upper_r <= req_i.wdata;
      else if (req_i.addr == OFS_LOWER_THRESHOLD)
        lower_r <= req_i.wdata;
      else if (req_i.addr == OFS_SCRATCH_ONE)
        scr_one_r <= req_i.wdata;
      else if (req_i.addr == OFS_SCRATCH_TWO)
        scr_two_r <= req_i.wdata;
      else if (req_i.addr == OFS_CAL_OFFSET)
        cal_r <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reload)
      unlock_r <= 1'b0;
    else if (req_i.wr && req_i.addr == OFS_NVM_UNLOCK)
      unlock_r <= req_i.wdata[NVM_WRITE_UNLOCK_BIT];
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.rd;
      if (req_i.rd)
      begin
        if (req_i.addr == OFS_UPPER_THRESHOLD)
          rdata_o <= upper_r;
        else if (req_i.addr == OFS_LOWER_THRESHOLD)
          rdata_o <= lower_r;
        else if (req_i.addr == OFS_NVM_UNLOCK)
          rdata_o <= {unlock_r, nvm_busy_o, 14'h0000};
        else if (req_i.addr == OFS_SCRATCH_ONE)
          rdata_o <= scr_one_r;
        else if (req_i.addr == OFS_SCRATCH_TWO)
          rdata_o <= scr_two_r;
        else if (req_i.addr == OFS_CAL_OFFSET)
          rdata_o <= cal_r;
        else
          rdata_o <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Offset correction of the linearized result
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      temp_result_o <= 16'h0000;
      temp_valid_o  <= 1'b0;
    end
    else
    begin
      temp_valid_o <= lin_valid_i;
      if (lin_valid_i)
        temp_result_o <= sat_add(lin_temp_i, cal_r);
    end
  end

  assign upper_threshold_o = upper_r;
  assign lower_threshold_o = lower_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_locked_no_prog: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state_r == ST_IDLE && !unlock_r && req_i.wr && !gcall_reset_i) |=> state_r == ST_IDLE)
    else $error("locked write started programming");
  a_unlock_prog: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state_r == ST_IDLE && unlock_r && wr_ok && !gcall_reset_i) |=> nvm_busy_o)
    else $error("unlocked write did not start programming");
  a_busy_mirror: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rvalid_o && $past(req_i.addr) == OFS_NVM_UNLOCK) |-> rdata_o[14] == $past(nvm_busy_o))
    else $error("busy bit mismatch");
  a_busy_release: assert property (@(posedge ref_clk_i) disable iff (srst_i || gcall_reset_i)
    (state_r == ST_LOAD) |-> ##[1:4] state_r == ST_IDLE)
    else $error("reload busy too long");
  a_upper_write: assert property (@(posedge ref_clk_i) disable iff (srst_i || gcall_reset_i)
    (state_r == ST_IDLE && req_i.wr && req_i.addr == OFS_UPPER_THRESHOLD)
    |=> upper_r == $past(req_i.wdata))
    else $error("upper threshold not written");
  a_lower_write: assert property (@(posedge ref_clk_i) disable iff (srst_i || gcall_reset_i)
    (state_r == ST_IDLE && req_i.wr && req_i.addr == OFS_LOWER_THRESHOLD)
    |=> lower_r == $past(req_i.wdata))
    else $error("lower threshold not written");
  a_reload_upper: assert property (@(posedge ref_clk_i)
    ($past(state_r) == ST_LOAD && state_r == ST_IDLE) |-> upper_r == nvm_mem[NVM_IDX_UPPER])
    else $error("upper threshold not reloaded");
  a_sat_range: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (lin_valid_i && !lin_temp_i[15] && !cal_r[15]) |=> !temp_result_o[15])
    else $error("positive sum wrapped");
  c_prog: cover property (@(posedge ref_clk_i) state_r == ST_IDLE ##1 state_r == ST_PROG);
  c_sat: cover property (@(posedge ref_clk_i) temp_valid_o && temp_result_o == TEMP_MAX_CODE);
  c_unlock: cover property (@(posedge ref_clk_i) unlock_r && wr_ok);

endmodule
`default_nettype wire

// file: testbench/tsr_host_model.sv
// Host-side model that issues single-word register requests to the bank.
`timescale 1ns/10ps
`default_nettype none
module tsr_host_model
  import tsr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        busy_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  tsr_req_t    req_o
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // A released request bus shows the inverted address, with inverted data after a write and zero data after a read, never stale values.
  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
    int n;
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hffff};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h0000};
    ok = 1'b0;
    d = 16'h0000;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_i;
      end
      else
        @(negedge ref_clk_i);
    end
  endtask

  task automatic wait_idle(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 60 && !ok; n++)
    begin
      @(negedge ref_clk_i);
      ok = (busy_i === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_temp_sensor_limit_nvm_regs.sv
// Self-checking testbench of the threshold and stored-copy register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_temp_sensor_limit_nvm_regs;
  import tsr_pkg::*;
  localparam int PROG = 10;
  logic        ref_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        gcall_reset_i = 1'b0;
  logic        lin_valid_i = 1'b0;
  logic [15:0] lin_temp_i = 16'h0000;
  tsr_req_t    req;
  logic [15:0] rdata, temp_res, upth, loth, v, eu, el, off;
  logic        rvalid, busy, tvalid;
  int          num_errors = 0, n_checks = 0, seed = 23016, i;
  bit          ok;

  always #4 ref_clk_i = ~ref_clk_i;

  tsr_regs #(.PROG_CYCLES(PROG)) uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .gcall_reset_i(gcall_reset_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .nvm_busy_o(busy), .lin_valid_i(lin_valid_i), .lin_temp_i(lin_temp_i),
    .temp_result_o(temp_res), .temp_valid_o(tvalid), .upper_threshold_o(upth),
    .lower_threshold_o(loth));

  tsr_host_model host (.ref_clk_i(ref_clk_i), .busy_i(busy), .rdata_i(rdata),
    .rvalid_i(rvalid), .req_o(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic hang(input string m);
    num_errors++;
    $display("wrong value at %0t: %s timed out", $time, m);
    end_sim();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, v, ok);
    if (!ok)
      hang("read");
    chk(v, exp, "register read");
  endtask

  task automatic idle;
    host.wait_idle(ok);
    if (!ok)
      hang("busy");
  endtask

  task automatic gcall;
    @(negedge ref_clk_i);
    gcall_reset_i = 1'b1;
    @(negedge ref_clk_i);
    gcall_reset_i = 1'b0;
    idle();
  endtask

  // Saturating sum, worked out one bit wider so overflow cannot wrap.
  function automatic logic [15:0] sat(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    if (s > 17'sd32767)
      return TEMP_MAX_CODE;
    if (s < -17'sd32768)
      return TEMP_MIN_CODE;
    return s[15:0];
  endfunction

  task automatic tchk(input logic [15:0] t, input logic [15:0] exp);
    int n;
    @(negedge ref_clk_i);
    lin_valid_i = 1'b1;
    lin_temp_i = t;
    @(negedge ref_clk_i);
    lin_valid_i = 1'b0;
    lin_temp_i = ~t;
    for (n = 0; n < 4 && tvalid !== 1'b1; n++)
      @(negedge ref_clk_i);
    if (tvalid !== 1'b1)
      hang("result");
    chk(temp_res, exp, "temperature result");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge ref_clk_i);
    chk({15'h0000, busy}, 16'h0001, "busy in reset");
    srst_i = 1'b0;
    @(negedge ref_clk_i);
    chk({15'h0000, busy}, 16'h0001, "busy in reload");
    idle();
    rchk(OFS_UPPER_THRESHOLD, 16'h6000);
    rchk(OFS_LOWER_THRESHOLD, 16'h8000);
    rchk(OFS_NVM_UNLOCK, 16'h0000);
    rchk(OFS_SCRATCH_ONE, RST_SCRATCH_ONE);
    rchk(OFS_SCRATCH_TWO, 16'h0000);
    rchk(OFS_CAL_OFFSET, 16'h0000);
    rchk(8'h00, 16'h0000);
    rchk(8'h08, 16'h0000);
    // Locked writes reach the registers only; a general call undoes them.
    for (i = 0; i < 4; i++)
    begin
      eu = 16'($random(seed));
      el = 16'($random(seed));
      host.wr(OFS_UPPER_THRESHOLD, eu);
      host.wr(OFS_LOWER_THRESHOLD, el);
      chk(upth, eu, "upper output");
      chk(loth, el, "lower output");
      rchk(OFS_UPPER_THRESHOLD, eu);
      rchk(OFS_LOWER_THRESHOLD, el);
      host.wr(OFS_SCRATCH_ONE, eu ^ el);
      rchk(OFS_SCRATCH_ONE, eu ^ el);
      chk({15'h0000, busy}, 16'h0000, "busy after locked write");
    end
    gcall();
    rchk(OFS_UPPER_THRESHOLD, 16'h6000);
    rchk(OFS_SCRATCH_ONE, RST_SCRATCH_ONE);
    // Unlocked write programs the stored copy and survives a general call.
    host.wr(OFS_NVM_UNLOCK, 16'h8000);
    rchk(OFS_NVM_UNLOCK, 16'h8000);
    eu = 16'($random(seed));
    host.wr(OFS_UPPER_THRESHOLD, eu);
    rchk(OFS_NVM_UNLOCK, 16'hc000);
    host.wr(OFS_LOWER_THRESHOLD, 16'h1111);
    rchk(OFS_LOWER_THRESHOLD, 16'h8000);
    idle();
    rchk(OFS_NVM_UNLOCK, 16'h8000);
    host.wr(OFS_SCRATCH_TWO, 16'h5a5a);
    idle();
    gcall();
    rchk(OFS_UPPER_THRESHOLD, eu);
    rchk(OFS_SCRATCH_TWO, 16'h5a5a);
    rchk(OFS_NVM_UNLOCK, 16'h0000);
    // Offset addition, with both saturation corners first.
    host.wr(OFS_CAL_OFFSET, 16'h2000);
    tchk(16'h7000, 16'h7fff);
    host.wr(OFS_CAL_OFFSET, 16'hffff);
    tchk(16'h8000, 16'h8000);
    for (i = 0; i < 8; i++)
    begin
      off = 16'($random(seed));
      v = 16'($random(seed));
      host.wr(OFS_CAL_OFFSET, off);
      tchk(v, sat(v, off));
    end
    end_sim();
  end
endmodule
`default_nettype wire
